// ### sim/dtc_partner.sv
`timescale 1ns/1ps
module dtc_partner(
	input wire logic i_ref_clk,
	input wire logic i_go,
	input wire logic [7:0] i_n,
	output logic o_pin,
	output logic o_busy
);
	logic [8:0] left = 9'h000;
	logic [3:0] ph = 4'h0;
	initial o_pin = 1'b1;
	assign o_busy = left != 9'h000;
	// Each level stands one machine cycle
	always @(posedge i_ref_clk) begin
		if (i_go) left <= {i_n, 1'b0};
		else if (o_busy) begin
			ph <= (ph == 4'hb) ? 4'h0 : ph + 4'h1;
			if (ph == 4'hb) begin
				o_pin <= ~o_pin;
				left <= left - 9'h001;
			end
		end
	end
endmodule

// ### sim/dtc_timers_asserts.sv
`timescale 1ns/1ps
module dtc_timers_asserts(
	input wire logic i_ref_clk, i_resetn, i_wr, i_rd, i_ack_zero, i_ack_one,
	input wire logic i_count_pin_zero, i_count_pin_one, i_gate_pin_zero,
	input wire logic i_gate_pin_one, o_ovf_flag_zero, o_ovf_flag_one,
	input wire logic o_rate_pulse,
	input wire logic [7:0] i_addr, i_wdata, o_rdata
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic [7:0] sh_mode, next_sh_mode;
	logic [1:0] sh_run, next_sh_run;
	always_comb begin
		next_sh_mode = sh_mode;
		next_sh_run = sh_run;
		if (!i_resetn) begin
			next_sh_mode = 8'h00;
			next_sh_run = 2'h0;
		end else if (i_wr && i_addr == 8'h89) next_sh_mode = i_wdata;
		else if (i_wr && i_addr == 8'h88) next_sh_run = {i_wdata[6], i_wdata[4]};
	end
	always_ff @(posedge i_ref_clk) begin
		sh_mode <= next_sh_mode;
		sh_run <= next_sh_run;
	end
	sequence s_rd(a);
		i_rd && i_addr == a;
	endsequence
	AST_RD_MODE: assert property (s_rd(8'h89) |=> o_rdata == $past(sh_mode))
		else $error("mode readback wrong");
	AST_RD_CTRL: assert property (s_rd(8'h88) |=> o_rdata[3:0] == 4'h0)
		else $error("control low nibble not zero");
	AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data without read");
	AST_RESET: assert property (disable iff (1'b0) !i_resetn |=>
		!o_ovf_flag_zero && !o_ovf_flag_one && !o_rate_pulse)
		else $error("outputs not cleared by reset");
	AST_HOLD0: assert property (o_ovf_flag_zero && !i_ack_zero && !i_wr
		|=> o_ovf_flag_zero) else $error("flag zero lost");
	AST_HOLD1: assert property (o_ovf_flag_one && !i_ack_one && !i_wr
		|=> o_ovf_flag_one) else $error("flag one lost");
	AST_RATE_GAP: assert property (o_rate_pulse |=> !o_rate_pulse [*8])
		else $error("rate pulses too close");
	AST_RUN0: assert property ($rose(o_ovf_flag_zero)
		|-> $past(sh_run[0]) || $past(i_wr)) else $error("flag zero while stopped");
	AST_RUN1: assert property ($rose(o_ovf_flag_one)
		|-> $past(sh_run[1]) || $past(i_wr)) else $error("flag one while stopped");
endmodule
bind dtc_timers dtc_timers_asserts u_dtc_timers_asserts(.*);

// ### sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, a0 = 0, a1 = 0, g0 = 0, g1 = 0;
	logic pgo = 0, p1 = 1, f0, f1, rp, p0, b0;
	logic [7:0] addr = 0, wd = 0, n = 8'h03, rdata;
	logic [7:0] tm[3] = '{8'h01, 8'h00, 8'h02}, th[3] = '{8'hff, 8'h05, 8'hf0};
	logic [7:0] el[3] = '{8'h01, 8'h01, 8'hf1}, eh[3] = '{8'h00, 8'h06, 8'hf0};
	logic ef[3] = '{1'b1, 1'b0, 1'b1};
	int err_total = 0, n_compared = 0, cyc = 0, pulses = 0;
	initial forever #4 clk = ~clk;
	dtc_timers u_dtc_timers(.i_ref_clk(clk), .i_resetn(rstn), .i_addr(addr),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .i_ack_zero(a0), .i_ack_one(a1),
		.i_count_pin_zero(p0), .i_count_pin_one(p1), .i_gate_pin_zero(g0),
		.i_gate_pin_one(g1), .o_rdata(rdata), .o_ovf_flag_zero(f0),
		.o_ovf_flag_one(f1), .o_rate_pulse(rp));
	dtc_partner u_dtc_partner(.i_ref_clk(clk), .i_go(pgo), .i_n(n),
		.o_pin(p0), .o_busy(b0));
	task complete_run;
		$display("mismatches %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (rp === 1'b1) pulses++;
		if (cyc > 5000) begin
			err_total++;
			complete_run();
		end
	end
	task step(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task wr8(logic [7:0] a, logic [7:0] d);
		addr = a;
		wd = d;
		wr = 1;
		step(1);
		wr = 0;
		step(1);
	endtask
	task rdc(logic [7:0] a, logic [7:0] e);
		addr = a;
		rd = 1;
		step(1);
		`CHK("rdata", e, rdata)
		rd = 0;
		step(1);
	endtask
	// Runs for exactly k machine cycles, then leaves the stop write due
	task run(logic [7:0] c, int k);
		wr8(8'h88, c);
		step(12 * k - 2);
	endtask
	task pins;
		pgo = 1;
		step(1);
		pgo = 0;
		repeat (200) if (b0 === 1'b1) step(1);
		step(30);
	endtask
	initial begin
		step(3);
		rstn = 1;
		rdc(8'h89, 8'h00);
		rdc(8'h88, 8'h00);
		rdc(8'h8a, 8'h00);
		rdc(8'h00, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr8(8'h89, tm[i]);
			wr8(8'h8a, 8'hfe);
			wr8(8'h8c, th[i]);
			run(8'h10, 3);
			`CHK("flag0", ef[i], f0)
			wr8(8'h88, 8'h00);
			rdc(8'h8a, el[i]);
			rdc(8'h8c, eh[i]);
		end
		wr8(8'h88, 8'ha0);
		`CHK("flags", 2'b11, {f1, f0})
		a0 = 1;
		a1 = 1;
		step(1);
		a0 = 0;
		a1 = 0;
		step(1);
		`CHK("flags", 2'b00, {f1, f0})
		wr8(8'h89, 8'h0d);
		wr8(8'h8a, 8'h00);
		wr8(8'h8c, 8'h00);
		wr8(8'h88, 8'h10);
		pins();
		g0 = 1;
		pins();
		wr8(8'h88, 8'h00);
		rdc(8'h8a, 8'h03);
		wr8(8'h89, 8'h13);
		wr8(8'h8a, 8'h00);
		wr8(8'h8b, 8'hfe);
		wr8(8'h8d, 8'hff);
		pulses = 0;
		run(8'h50, 3);
		`CHK("flags", 2'b00, {f1, f0})
		wr8(8'h88, 8'h00);
		`CHK("pulses", 1, pulses)
		rdc(8'h8a, 8'h03);
		rdc(8'h8c, 8'h03);
		rdc(8'h8b, 8'h01);
		wr8(8'h89, 8'h33);
		run(8'h40, 3);
		wr8(8'h88, 8'h00);
		rdc(8'h8b, 8'h01);
		complete_run();
	end
endmodule

// ### verilog/dtc_defs.svh
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_TL0 8'h8a
`define DTC_ADDR_TL1 8'h8b
`define DTC_ADDR_TH0 8'h8c
`define DTC_ADDR_TH1 8'h8d
`define DTC_OSC_PER_MC 4'd12
`define DTC_MC_LAST 4'hb
`define DTC_SAMPLE_PHASE 4'h9
`define DTC_PRESC_MAX 5'h1f
`define DTC_BYTE_MAX 8'hff
`define DTC_CTRL_OVF1 7
`define DTC_CTRL_RUN1 6
`define DTC_CTRL_OVF0 5
`define DTC_CTRL_RUN0 4
`define DTC_MOD_GATE 3
`define DTC_MOD_CSRC 2
`define DTC_MOD_HI 1
`define DTC_MOD_LO 0
`define DTC_MOD_T1_BASE 4
`define DTC_RST_BYTE 8'h00
`define DTC_RST_PHASE 4'h0

`endif

// ### verilog/dtc_pkg.sv
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_PRESC = 2'b00,
		DTC_MODE_WIDE = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;
endpackage

// ### verilog/dtc_timers.sv
`timescale 1ns/1ps
`include "dtc_defs.svh"

// Function
// [RULE1] Timer function counts one per machine cycle
// [RULE2] Counter samples pin per cycle, counts falls
// [RULE3] Falling edge recognised over two machine cycles
// [RULE4] Source holds each level one machine cycle
// [RULE5] Mode 0: high byte after divide-by-32
// [RULE6] Mode 1: bytes cascade into 16 bits
// [RULE7] Mode 2: low byte reloads from high
// [RULE8] Timer 0 mode 3 splits into two
// [RULE9] Timer 1 mode 3 holds count
// [RULE10] Split: timer 1 no flag, still pulses
// [RULE11] Gate bit requires gate pin high
// [RULE12] Count-source bit picks machine or pin
// [RULE13] Overflow sets interrupt request flag
// [RULE14] Mode register: timer 1 high nibble
// [RULE15] Overflow flags set, cleared on service
// [RULE16] Run bits switch timers immediately
// [RULE17] Prescaler is low five low-byte bits
// [RULE18] Reset clears all control and counts
module dtc_timers
	import dtc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_ack_zero,
	input wire logic i_ack_one,
	input wire logic i_count_pin_zero,
	input wire logic i_count_pin_one,
	input wire logic i_gate_pin_zero,
	input wire logic i_gate_pin_one,
	output logic [7:0] o_rdata,
	output logic o_ovf_flag_zero,
	output logic o_ovf_flag_one,
	output logic o_rate_pulse
);

	logic [3:0] phase;
	logic [3:0] next_phase;
	logic [7:0] timer_mode_control;
	logic [7:0] next_timer_mode_control;
	logic run_ctl_zero;
	logic run_ctl_one;
	logic next_run_ctl_zero;
	logic next_run_ctl_one;
	logic [7:0] low_byte [2];
	logic [7:0] high_byte [2];
	logic [7:0] next_low_byte [2];
	logic [7:0] next_high_byte [2];
	logic [1:0] pin_prev;
	logic [1:0] pin_now;
	logic [1:0] next_pin_prev;
	logic [1:0] next_pin_now;
	logic next_ovf_zero;
	logic next_ovf_one;
	logic next_rate_pulse;
	logic [7:0] next_rdata;
	logic mc_tick;
	logic [1:0] tick;
	logic [1:0] enable;
	logic [1:0] ovf;
	logic hi0_split_ovf;
	logic split;
	logic wr_ctrl;
	dtc_mode_t mode [2];

	// Machine cycle: one tick every twelve reference clocks
	always_comb begin
		next_phase = (phase == `DTC_MC_LAST) ? 4'h0 : phase + 4'h1;
	end
	assign mc_tick = (phase == `DTC_MC_LAST); // [RULE1]

	// Split mode hands timer 1's run and flag to high byte zero
	assign split = (mode[0] == DTC_MODE_SPLIT);

	// Control write decode used only by the flag logic
	assign wr_ctrl = i_wr && (i_addr == `DTC_ADDR_CTRL);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_src
			localparam int B = gi * `DTC_MOD_T1_BASE;
			logic cnt_pin;
			logic gate_pin;
			logic run_bit;
			logic gate_bit;
			logic csrc_bit;
			assign cnt_pin = gi ? i_count_pin_one : i_count_pin_zero;
			assign gate_pin = gi ? i_gate_pin_one : i_gate_pin_zero;
			assign run_bit = gi ? run_ctl_one : run_ctl_zero;
			// [RULE14] each timer reads its own nibble
			assign mode[gi] = dtc_mode_t'(
				timer_mode_control[B + `DTC_MOD_HI:B + `DTC_MOD_LO]);
			// Gate and source bits of this timer's nibble
			assign gate_bit = timer_mode_control[B + `DTC_MOD_GATE];
			assign csrc_bit = timer_mode_control[B + `DTC_MOD_CSRC];
			// [RULE11] [RULE16]
			assign enable[gi] = run_bit & (~gate_bit | gate_pin);
			// [RULE12] [RULE2] [RULE3]
			assign tick[gi] = csrc_bit ?
				(mc_tick & pin_prev[gi] & ~pin_now[gi]) : mc_tick;
			always_comb begin
				next_pin_now[gi] = pin_now[gi];
				next_pin_prev[gi] = pin_prev[gi];
				// Sample once per machine cycle at a fixed phase
				if (phase == `DTC_SAMPLE_PHASE) begin
					next_pin_prev[gi] = pin_now[gi];
					next_pin_now[gi] = cnt_pin; // [RULE2]
				end
			end
		end
	endgenerate

	always_comb begin
		next_low_byte = low_byte;
		next_high_byte = high_byte;
		ovf = 2'b00;
		hi0_split_ovf = 1'b0;
		for (int t = 0; t < 2; t++) begin
			if (enable[t] && tick[t]) begin
				unique case (mode[t])
					DTC_MODE_PRESC: begin
						// [RULE5] [RULE17]
						next_low_byte[t] = {3'h0, low_byte[t][4:0] + 5'h1};
						if (low_byte[t][4:0] == `DTC_PRESC_MAX) begin
							next_high_byte[t] = high_byte[t] + 8'h1;
							ovf[t] = (high_byte[t] == `DTC_BYTE_MAX);
						end
					end
					DTC_MODE_WIDE: begin
						// [RULE6]
						next_low_byte[t] = low_byte[t] + 8'h1;
						if (low_byte[t] == `DTC_BYTE_MAX) begin
							next_high_byte[t] = high_byte[t] + 8'h1;
							ovf[t] = (high_byte[t] == `DTC_BYTE_MAX);
						end
					end
					DTC_MODE_RELOAD: begin
						// [RULE7]
						if (low_byte[t] == `DTC_BYTE_MAX) begin
							next_low_byte[t] = high_byte[t];
							ovf[t] = 1'b1;
						end else begin
							next_low_byte[t] = low_byte[t] + 8'h1;
						end
					end
					DTC_MODE_SPLIT: begin
						// [RULE8] timer 0 low byte; [RULE9] timer 1 holds
						if (t == 0) begin
							next_low_byte[0] = low_byte[0] + 8'h1;
							ovf[0] = (low_byte[0] == `DTC_BYTE_MAX);
						end
					end
				endcase
			end
		end
		// [RULE8] split high byte: machine cycles under timer 1 run bit
		if (split && run_ctl_one && mc_tick) begin
			next_high_byte[0] = high_byte[0] + 8'h1;
			hi0_split_ovf = (high_byte[0] == `DTC_BYTE_MAX);
		end
		// Software writes to count bytes win over counting
		if (i_wr) begin
			unique case (i_addr)
				`DTC_ADDR_TL0: next_low_byte[0] = i_wdata;
				`DTC_ADDR_TL1: next_low_byte[1] = i_wdata;
				`DTC_ADDR_TH0: next_high_byte[0] = i_wdata;
				`DTC_ADDR_TH1: next_high_byte[1] = i_wdata;
				default: begin
				end
			endcase
		end
	end

	// Flags: hardware set wins over service acknowledge
	always_comb begin
		next_ovf_zero = (o_ovf_flag_zero & ~i_ack_zero) | ovf[0]; // [RULE13]
		// [RULE10] timer 1 flag owned by split high byte in mode 3
		next_ovf_one = split ?
			((o_ovf_flag_one & ~i_ack_one) | hi0_split_ovf) :
			((o_ovf_flag_one & ~i_ack_one) | ovf[1]); // [RULE15]
		// A control write loads the flags, yet a same-cycle rollover wins
		if (wr_ctrl) begin
			next_ovf_zero = i_wdata[`DTC_CTRL_OVF0] | ovf[0];
			next_ovf_one = i_wdata[`DTC_CTRL_OVF1] |
				(split ? hi0_split_ovf : ovf[1]);
		end
		// Timer 1 rollover still feeds the rate generator when split
		next_rate_pulse = ovf[1]; // [RULE10]
	end

	// Flags and rate pulse
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_ovf_flag_zero <= 1'b0; // [RULE18]
			o_ovf_flag_one <= 1'b0;
			o_rate_pulse <= 1'b0;
		end else begin
			o_ovf_flag_zero <= next_ovf_zero;
			o_ovf_flag_one <= next_ovf_one;
			o_rate_pulse <= next_rate_pulse;
		end
	end

	// Mode register and run bits
	always_comb begin
		next_timer_mode_control = timer_mode_control;
		next_run_ctl_zero = run_ctl_zero;
		next_run_ctl_one = run_ctl_one;
		if (i_wr) begin
			unique case (i_addr)
				`DTC_ADDR_MODE: next_timer_mode_control = i_wdata; // [RULE14]
				`DTC_ADDR_CTRL: begin
					next_run_ctl_zero = i_wdata[`DTC_CTRL_RUN0]; // [RULE16]
					next_run_ctl_one = i_wdata[`DTC_CTRL_RUN1];
				end
				default: begin
				end
			endcase
		end
	end

	// Control state
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			timer_mode_control <= `DTC_RST_BYTE; // [RULE18]
			run_ctl_zero <= 1'b0;
			run_ctl_one <= 1'b0;
		end else begin
			timer_mode_control <= next_timer_mode_control;
			run_ctl_zero <= next_run_ctl_zero;
			run_ctl_one <= next_run_ctl_one;
		end
	end

	// Read data stands one cycle; unmapped or idle reads give zero
	always_comb begin
		next_rdata = `DTC_RST_BYTE;
		if (i_rd) begin
			unique case (i_addr)
				`DTC_ADDR_MODE: next_rdata = timer_mode_control;
				`DTC_ADDR_CTRL: begin
					next_rdata[`DTC_CTRL_OVF1] = o_ovf_flag_one;
					next_rdata[`DTC_CTRL_RUN1] = run_ctl_one;
					next_rdata[`DTC_CTRL_OVF0] = o_ovf_flag_zero;
					next_rdata[`DTC_CTRL_RUN0] = run_ctl_zero;
				end
				`DTC_ADDR_TL0: next_rdata = low_byte[0];
				`DTC_ADDR_TL1: next_rdata = low_byte[1];
				`DTC_ADDR_TH0: next_rdata = high_byte[0];
				`DTC_ADDR_TH1: next_rdata = high_byte[1];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			o_rdata <= `DTC_RST_BYTE;
		end else begin
			o_rdata <= next_rdata;
		end
	end

	// Phase restarts at zero, so the first tick is twelve clocks out
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			phase <= `DTC_RST_PHASE;
		end else begin
			phase <= next_phase;
		end
	end

	// Sample history starts low, so an idle-high pin gives no false fall
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			pin_prev <= 2'b00;
			pin_now <= 2'b00;
		end else begin
			pin_prev <= next_pin_prev;
			pin_now <= next_pin_now;
		end
	end

	// Count registers, one pair per timer
	generate
		for (gi = 0; gi < 2; gi++) begin : g_cnt
			always_ff @(posedge i_ref_clk) begin
				if (!i_resetn) begin
					low_byte[gi] <= `DTC_RST_BYTE; // [RULE18]
					high_byte[gi] <= `DTC_RST_BYTE;
				end else begin
					low_byte[gi] <= next_low_byte[gi];
					high_byte[gi] <= next_high_byte[gi];
				end
			end
		end
	endgenerate

endmodule
